// >>> cfm_defs.svh
// constant definitions for the cpu flag and memory map block
`ifndef CFM_DEFS_SVH
`define CFM_DEFS_SVH
`define CFM_FLAG_W 11
`define CFM_FLG_C 0
`define CFM_FLG_D 1
`define CFM_FLG_Z 2
`define CFM_FLG_S 3
`define CFM_FLG_B 4
`define CFM_FLG_O 5
`define CFM_FLG_I 6
`define CFM_FLG_U 7
`define CFM_FLG_RSV 11'h000
`define CFM_FLG_PL_LO 8
`define CFM_FLG_WMASK 11'h7FD
`define CFM_FLG_RST 11'h000
`define CFM_SB_RST 16'h0000
`define CFM_REG_SB 2'h0
`define CFM_REG_FLG 2'h1
`define CFM_REG_STAT 2'h2
`define CFM_SFR_LO 20'h00000
`define CFM_SFR_HI 20'h002FF
`define CFM_SFR_USED_HI 20'h000FF
`define CFM_FMR_LO 20'h001B3
`define CFM_FMR_HI 20'h001B7
`define CFM_RAM_LO 20'h00400
`define CFM_RAM_HI_DEF 20'h007FF
`define CFM_ROM_LO_DEF 20'h0C000
`define CFM_ROM_HI 20'h0FFFF
`define CFM_VEC_LO 20'h0FFDC
`define CFM_OFS_ADDR 20'h0FFFF
`define CFM_SWI_HW_MAX 6'h1F
`endif

// >>> cfm_pkg.sv
// types for the cpu flag and memory map block
package cfm_pkg;
  typedef struct packed {
    logic [2:0] pl;
    logic u;
    logic i;
    logic o;
    logic b;
    logic s;
    logic z;
    logic d;
    logic c;
  } cfm_flag_t;

  typedef struct packed {
    logic we;
    logic c;
    logic z;
    logic s;
    logic o;
  } cfm_alu_t;

  typedef struct packed {
    logic sfr;
    logic sfr_rsv;
    logic ram;
    logic rom;
    logic vec;
    logic ofs;
    logic wr_block;
  } cfm_dec_t;

  typedef enum logic [1:0] {
    CFM_REGION_NONE,
    CFM_REGION_SFR,
    CFM_REGION_MEM
  } cfm_region_t;
endpackage : cfm_pkg

// >>> cfm_core.sv
// cpu state registers, interrupt gating and address map decode
//
// Design decisions made here: the placing of the registers and strobed register access.
`include "cfm_defs.svh"

module cfm_core (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire cfm_pkg::cfm_alu_t alu_res,
  input wire logic irq_req,
  input wire logic irq_nmi,
  input wire logic [2:0] irq_level,
  input wire logic swi_exec,
  input wire logic [5:0] swi_num,
  input wire logic [19:0] mem_addr,
  input wire logic mem_wr,
  input wire logic [19:0] rom_lo,
  input wire logic [19:0] ram_hi,
  output logic irq_ack,
  output logic bank_sel,
  output logic stack_sel_task,
  output logic [15:0] static_base,
  output cfm_pkg::cfm_flag_t cpu_flag_word,
  output cfm_pkg::cfm_dec_t mem_dec,
  output cfm_pkg::cfm_region_t mem_region
);
  import cfm_pkg::*;

  logic [15:0] static_base_r;
  cfm_flag_t flag_r;
  cfm_flag_t flag_nxt;
  logic take_irq;
  logic irq_ack_r;
  logic bank_sel_r;
  logic stack_sel_r;
  cfm_dec_t dec_r;
  cfm_dec_t dec_nxt;
  cfm_region_t region_r;
  cfm_region_t region_nxt;
  logic [15:0] rdata_r;

  function automatic logic in_range(input logic [19:0] a,
                                    input logic [19:0] lo,
                                    input logic [19:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // non-maskable requests bypass enable and level
  always_comb begin
    take_irq = irq_req && (irq_nmi ||
      (flag_r.i && (irq_level > flag_r.pl)));
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      static_base_r <= `CFM_SB_RST;
    end else if (reg_wr && reg_addr == `CFM_REG_SB) begin
      static_base_r <= reg_wdata;
    end
  end

  // priority: interrupt entry over software write over alu update
  always_comb begin
    flag_nxt = flag_r;
    if (alu_res.we) begin
      flag_nxt.c = alu_res.c;
      flag_nxt.z = alu_res.z;
      flag_nxt.s = alu_res.s;
      flag_nxt.o = alu_res.o;
    end
    if (reg_wr && reg_addr == `CFM_REG_FLG) begin
      // debug bit is forced low; software is to leave it at zero
      flag_nxt = cfm_flag_t'(reg_wdata[`CFM_FLAG_W-1:0] &
        `CFM_FLG_WMASK);
    end
    if (take_irq) begin
      flag_nxt.i = 1'b0;
      flag_nxt.u = 1'b0;
    end
    if (swi_exec) begin
      flag_nxt.i = 1'b0;
      if (swi_num <= `CFM_SWI_HW_MAX) begin
        flag_nxt.u = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flag_r <= cfm_flag_t'(`CFM_FLG_RST);
    end else begin
      flag_r <= flag_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_ack_r <= 1'b0;
      bank_sel_r <= 1'b0;
      stack_sel_r <= 1'b0;
    end else begin
      irq_ack_r <= take_irq;
      bank_sel_r <= flag_nxt.b;
      stack_sel_r <= flag_nxt.u;
    end
  end

  // decode of the full 20-bit space; everything else falls to none
  always_comb begin
    dec_nxt = '0;
    region_nxt = CFM_REGION_NONE;
    dec_nxt.sfr = in_range(mem_addr, `CFM_SFR_LO, `CFM_SFR_HI);
    dec_nxt.sfr_rsv = dec_nxt.sfr &&
      !(in_range(mem_addr, `CFM_SFR_LO, `CFM_SFR_USED_HI) ||
      in_range(mem_addr, `CFM_FMR_LO, `CFM_FMR_HI));
    dec_nxt.ram = in_range(mem_addr, `CFM_RAM_LO, ram_hi);
    dec_nxt.rom = in_range(mem_addr, rom_lo, `CFM_ROM_HI);
    dec_nxt.vec = in_range(mem_addr, `CFM_VEC_LO, `CFM_ROM_HI);
    dec_nxt.ofs = (mem_addr == `CFM_OFS_ADDR);
    // program writes never reach rom or the option word
    dec_nxt.wr_block = mem_wr && (dec_nxt.rom || dec_nxt.ofs ||
      dec_nxt.sfr_rsv);
    if (dec_nxt.sfr) begin
      region_nxt = CFM_REGION_SFR;
    end else if (dec_nxt.ram || dec_nxt.rom) begin
      region_nxt = CFM_REGION_MEM;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dec_r <= '0;
      region_r <= CFM_REGION_NONE;
    end else begin
      dec_r <= dec_nxt;
      region_r <= region_nxt;
    end
  end

  // reserved bits read as zero; read data valid only the cycle after
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `CFM_REG_SB: rdata_r <= static_base_r;
        `CFM_REG_FLG: rdata_r <= {5'h00, flag_r};
        `CFM_REG_STAT: rdata_r <= {13'h0000, irq_ack_r, stack_sel_r,
          bank_sel_r};
        default: rdata_r <= '0;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  assign reg_rdata = rdata_r;
  assign irq_ack = irq_ack_r;
  assign bank_sel = bank_sel_r;
  assign stack_sel_task = stack_sel_r;
  assign static_base = static_base_r;
  assign cpu_flag_word = flag_r;
  assign mem_dec = dec_r;
  assign mem_region = region_r;

  a_ack_clears_ie: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq_ack_r |-> !flag_r.i)
    else $error("enable flag set after acknowledge");
  a_ack_clears_u: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq_ack_r |-> !flag_r.u)
    else $error("stack flag set after acknowledge");
  a_mask_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (irq_req && !irq_nmi && !flag_r.i) |=> !irq_ack_r)
    else $error("masked interrupt acknowledged");
  a_level_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (irq_req && !irq_nmi && irq_level <= flag_r.pl) |=> !irq_ack_r)
    else $error("low priority interrupt acknowledged");
  a_taken_ok: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (irq_req && !irq_nmi && flag_r.i && irq_level > flag_r.pl)
    |=> irq_ack_r)
    else $error("eligible interrupt not acknowledged");
  a_alu_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (alu_res.we && !reg_wr) |=> (flag_r.z == $past(alu_res.z) &&
    flag_r.c == $past(alu_res.c)))
    else $error("zero or carry flag not captured");
  a_alu_sign_ovf: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (alu_res.we && !reg_wr) |=> (flag_r.s == $past(alu_res.s) &&
    flag_r.o == $past(alu_res.o)))
    else $error("sign or overflow flag not captured");
  a_bank_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bank_sel_r == flag_r.b && stack_sel_r == flag_r.u)
    else $error("bank or stack select out of step");
  a_ofs_locked: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mem_wr && mem_addr == `CFM_OFS_ADDR) |=> dec_r.wr_block)
    else $error("option word write not blocked");
  a_rd_timing: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == `CFM_REG_SB) |=>
    rdata_r == $past(static_base_r))
    else $error("static base read data wrong");

  // the debug bit must never be stored as one
  a_debug_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !flag_r.d)
    else $error("debug flag stored as one");
  a_swi_clears_ie: assert property (@(posedge sys_clk) disable iff (!rst_n)
    swi_exec |=> !flag_r.i)
    else $error("enable flag set after software interrupt");
  a_swi_low_u: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (swi_exec && swi_num <= `CFM_SWI_HW_MAX) |=> !flag_r.u)
    else $error("stack flag set after low software vector");
  a_sb_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `CFM_REG_SB) |=>
    static_base_r == $past(reg_wdata))
    else $error("static base write lost");
  a_flag_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `CFM_REG_FLG && !take_irq && !swi_exec) |=>
    flag_r == cfm_flag_t'($past(reg_wdata[`CFM_FLAG_W-1:0]) &
    `CFM_FLG_WMASK))
    else $error("flag word write lost");
  // read data must not linger, software relies on one-cycle data
  a_rd_idle_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !reg_rd |=> rdata_r == '0)
    else $error("read data left standing");
  a_sfr_decode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mem_addr <= `CFM_SFR_HI) |=> dec_r.sfr)
    else $error("peripheral address not decoded");
  a_vec_decode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mem_addr >= `CFM_VEC_LO && mem_addr <= `CFM_ROM_HI) |=>
    dec_r.vec)
    else $error("vector table address not decoded");
  a_ram_base: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mem_addr == `CFM_RAM_LO && ram_hi >= `CFM_RAM_LO) |=>
    dec_r.ram)
    else $error("ram base not decoded");
  a_rom_top: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mem_addr == `CFM_ROM_HI && rom_lo <= `CFM_ROM_HI) |=>
    (dec_r.rom && dec_r.ofs))
    else $error("rom top or option word not decoded");
  a_high_none: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mem_addr > `CFM_ROM_HI && mem_addr > ram_hi) |=>
    region_r == CFM_REGION_NONE)
    else $error("unmapped address given a region");
endmodule : cfm_core

// >>> cfm_alu_model.sv
// behavioural alu stand-in that posts flag updates from a 16-bit add
module cfm_alu_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [15:0] a,
  input wire logic [15:0] b,
  output cfm_pkg::cfm_alu_t alu_res
);
  timeunit 1ns;
  timeprecision 1ns;
  import cfm_pkg::*;
  logic [16:0] sum;
  assign sum = {1'b0, a} + {1'b0, b};
  // one registered pulse per go, like a real execute stage
  always_ff @(posedge sys_clk) begin
    alu_res.we <= go;
    alu_res.c <= sum[16];
    alu_res.z <= (sum[15:0] == 16'h0000);
    alu_res.s <= sum[15];
    alu_res.o <= (a[15] == b[15]) && (sum[15] != a[15]);
  end
endmodule : cfm_alu_model

// >>> cpu_flags_and_memory_map_tb_top.sv
// self-checking bench for the flag, base and decode block
module cpu_flags_and_memory_map_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cfm_pkg::*;
  logic sys_clk, rst_n, reg_wr, reg_rd, irq_req, irq_nmi, swi_exec;
  logic mem_wr, go, irq_ack, bank_sel, stack_sel_task;
  logic [1:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, static_base, a, b;
  logic [2:0] irq_level;
  logic [5:0] swi_num;
  logic [19:0] mem_addr;
  cfm_alu_t alu_res;
  cfm_flag_t fl;
  cfm_dec_t dec;
  cfm_region_t region;
  cfm_region_t rtab [15] = '{CFM_REGION_SFR, CFM_REGION_NONE,
    CFM_REGION_SFR, CFM_REGION_SFR, CFM_REGION_MEM, CFM_REGION_NONE,
    CFM_REGION_NONE, CFM_REGION_MEM, CFM_REGION_NONE, CFM_REGION_MEM,
    CFM_REGION_MEM, CFM_REGION_MEM, CFM_REGION_MEM, CFM_REGION_NONE,
    CFM_REGION_MEM};
  int errors, checks;
  // entry: address, then nibble {write, field bit}, then expected bit
  logic [27:0] dtab [15] = '{28'h002FF61, 28'h0030060, 28'h00100D1,
    28'h0010081, 28'h0040041, 28'h003FF40, 28'h0080040, 28'h0C00031,
    28'h0BFFF30, 28'h0FFDC21, 28'h0FFDB20, 28'h0FFFF91, 28'h0FFFF81,
    28'hFFFFF30, 28'h0040080};

  cfm_alu_model alu_u (.sys_clk(sys_clk), .go(go), .a(a), .b(b),
    .alu_res(alu_res));
  cfm_core dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .alu_res(alu_res), .irq_req(irq_req),
    .irq_nmi(irq_nmi), .irq_level(irq_level), .swi_exec(swi_exec),
    .swi_num(swi_num), .mem_addr(mem_addr), .mem_wr(mem_wr),
    .rom_lo(20'h0C000), .ram_hi(20'h007FF), .irq_ack(irq_ack),
    .bank_sel(bank_sel), .stack_sel_task(stack_sel_task),
    .static_base(static_base), .cpu_flag_word(fl), .mem_dec(dec),
    .mem_region(region));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] ad, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] ad, input logic [15:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd

  task automatic alu(input logic [15:0] x, input logic [15:0] y);
    @(posedge sys_clk);
    go <= 1'b1;
    a <= x;
    b <= y;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : alu

  task automatic irq(input logic n, input logic [2:0] l, input logic e);
    @(posedge sys_clk);
    irq_req <= 1'b1;
    irq_nmi <= n;
    irq_level <= l;
    @(posedge sys_clk);
    #1 chk(irq_ack, e);
    @(posedge sys_clk);
    irq_req <= 1'b0;
  endtask : irq

  task automatic swi(input logic [5:0] n);
    @(posedge sys_clk);
    swi_exec <= 1'b1;
    swi_num <= n;
    @(posedge sys_clk);
    swi_exec <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : swi

  initial begin
    #100000;
    errors++;
    report_and_stop();
  end

  initial begin
    {rst_n, reg_wr, reg_rd, irq_req, irq_nmi, swi_exec, mem_wr, go} = '0;
    {reg_addr, reg_wdata, a, b, irq_level, swi_num, mem_addr} = '0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(2'h0, 16'h0000);
    rd(2'h1, 16'h0000);
    wr(2'h0, 16'hA5C3);
    rd(2'h0, 16'hA5C3);
    chk(static_base, 16'hA5C3);
    wr(2'h3, 16'hFFFF);
    rd(2'h3, 16'h0000);
    rd(2'h0, 16'hA5C3);
    // debug and reserved bits written as zero
    wr(2'h1, 16'h07FD);
    rd(2'h1, 16'h07FD);
    rd(2'h2, 16'h0003);
    chk({bank_sel, stack_sel_task}, 2'b11);
    alu(16'h7FFF, 16'h0001);
    chk({fl.o, fl.s, fl.z, fl.c}, 4'b1100);
    alu(16'hFFFF, 16'h0001);
    chk({fl.o, fl.s, fl.z, fl.c}, 4'b0011);
    alu(16'h8000, 16'h8000);
    chk({fl.o, fl.s, fl.z, fl.c}, 4'b1011);
    wr(2'h1, 16'h0000);
    chk({bank_sel, stack_sel_task}, 2'b00);
    wr(2'h1, 16'h03C0);
    irq(1'b0, 3'h3, 1'b0);
    irq(1'b0, 3'h4, 1'b1);
    chk({fl.i, fl.u}, 2'b00);
    irq(1'b0, 3'h7, 1'b0);
    wr(2'h1, 16'h0740);
    irq(1'b0, 3'h7, 1'b0);
    wr(2'h1, 16'h00C0);
    irq(1'b1, 3'h0, 1'b1);
    chk({fl.i, fl.u}, 2'b00);
    wr(2'h1, 16'h00C0);
    swi(6'h20);
    chk({fl.i, fl.u}, 2'b01);
    wr(2'h1, 16'h00C0);
    swi(6'h1F);
    chk({fl.i, fl.u}, 2'b00);
    foreach (dtab[k]) begin
      @(posedge sys_clk);
      mem_addr <= dtab[k][27:8];
      mem_wr <= dtab[k][7];
      @(posedge sys_clk);
      #1 chk(dec[dtab[k][6:4]], dtab[k][0]);
      chk(region, rtab[k]);
    end
    report_and_stop();
  end
endmodule : cpu_flags_and_memory_map_tb_top
